// ### rtl/bit_timer.sv
// Time quantum prescaler and bit segment sequencer
`timescale 1ns/100ps
`default_nettype none
module bit_timer import can_cfg_pkg::*; (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic run, // Bus operation active
  input wire bit_timing_t timing, // Prescaler and segments
  output logic tq_tick, // One quantum elapsed
  output logic sample_pulse, // Sample point
  output logic bit_start // Start of sync segment
);
  logic [9:0] presc_cnt_r;
  logic [4:0] tq_cnt_r;
  seg_state_t state_r;
  logic tick_nxt;

  assign tick_nxt = run && (presc_cnt_r == timing.presc);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt_r <= 10'h000;
    end else if (!run || tick_nxt) begin
      presc_cnt_r <= 10'h000;
    end else begin
      presc_cnt_r <= presc_cnt_r + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tq_tick <= 1'b0;
    end else begin
      tq_tick <= tick_nxt;
    end
  end

  // sync, phase one, sample, phase two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SEG_IDLE;
      tq_cnt_r <= 5'h00;
      sample_pulse <= 1'b0;
      bit_start <= 1'b0;
    end else begin
      sample_pulse <= 1'b0;
      bit_start <= 1'b0;
      if (!run) begin
        state_r <= SEG_IDLE;
        tq_cnt_r <= 5'h00;
      end else begin
        case (state_r)
          SEG_IDLE: begin
            state_r <= SEG_SYNC;
            bit_start <= 1'b1;
          end
          SEG_SYNC: begin
            if (tick_nxt) begin
              state_r <= SEG_ONE;
              tq_cnt_r <= 5'h01;
            end
          end
          SEG_ONE: begin
            if (tick_nxt) begin
              if (tq_cnt_r >= timing.seg1) begin
                state_r <= SEG_TWO;
                tq_cnt_r <= 5'h01;
                sample_pulse <= 1'b1;
              end else begin
                tq_cnt_r <= tq_cnt_r + 5'h01;
              end
            end
          end
          SEG_TWO: begin
            if (tick_nxt) begin
              if (tq_cnt_r >= {1'b0, timing.seg2}) begin
                state_r <= SEG_SYNC;
                tq_cnt_r <= 5'h00;
                bit_start <= 1'b1;
              end else begin
                tq_cnt_r <= tq_cnt_r + 5'h01;
              end
            end
          end
          default: begin
            state_r <= SEG_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/can_cfg_pkg.sv
// Types shared by the mailbox block and its helpers
package can_cfg_pkg;

  typedef struct packed {
    logic [9:0] presc;
    logic [4:0] seg1;
    logic [3:0] seg2;
    logic [1:0] resync_jump_width;
  } bit_timing_t;

  typedef struct packed {
    logic valid;
    logic ok;
    logic [4:0] mbox;
  } tx_event_t;

  typedef struct packed {
    logic valid;
    logic own;
    logic [31:0] match;
  } rx_frame_t;

  typedef enum logic [1:0] {
    SEG_IDLE = 2'b00,
    SEG_SYNC = 2'b01,
    SEG_ONE = 2'b10,
    SEG_TWO = 2'b11
  } seg_state_t;

endpackage

// ### rtl/can_cfg_regs.svh
// Register offsets, field positions and reset values of the mailbox block
`ifndef CAN_CFG_REGS_SVH
`define CAN_CFG_REGS_SVH

`define MBOX_N 32
`define MBOX_IDX_W 5
`define PRESC_W 10
`define PRESC_MAX 10'h3ff

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define A_CTRL 12'h000
`define A_BITCFG 12'h004
`define A_STATUS 12'h008
`define A_MCTL_BASE 12'h100
`define MCTL_PAGE 5'h02

// ****************************************
// Control register fields
// ****************************************
`define CTRL_CONFIG 0
`define CTRL_SELF_TEST 1
`define CTRL_QUEUE_SEL 2
`define CTRL_RST 32'h0000_0001

// ****************************************
// Bit timing register fields
// ****************************************
`define BT_PRESC_LSB 0
`define BT_SEG1_LSB 16
`define BT_SEG2_LSB 24
`define BT_SJW_LSB 28
`define BT_RST 32'h1002_0005
`define BT_MASK 32'h3f1f_03ff

// ****************************************
// Status register fields
// ****************************************
`define ST_CONFIG 0
`define ST_SELF_TEST 1
`define ST_QUEUE_SEL 2
`define ST_STORED 3
`define ST_ACK_SELF 4
`define ST_IDX_LSB 8

// ****************************************
// Mailbox control register fields
// ****************************************
`define MC_TX_DONE 0
`define MC_TX_ABORT_DONE 1
`define MC_RX_DONE 2
`define MC_SINGLE 4
`define MC_RX_REQ 6
`define MC_TX_REQ 7
`define MCTL_RST 8'h00

`endif

// ### rtl/can_mailbox_cfg.sv
// Bit timing and mailbox mode registers of one CAN channel, APB slave
//
// Overview of operation
// - Quantum clock is source clock divided by prescaler field plus one.
// - Bit is sync quantum, phase one, phase two; sample between phases.
// - Queue select 0 gives per-mailbox mode; 1 stops mailbox reception and transmission.
// - Each mailbox control register holds transmit, receive, single bits.
// - All three bits zero means mailbox disabled or abort in progress.
// - Single bit alone follows any ended single transmit attempt or single reception.
// - Receive request alone receives frames; with single bit, once only.
// - Transmit request alone sends frame; with single bit, one attempt.
// - Received frame goes to first mailbox matching mode and filter.
// - Among several qualifying mailboxes the lowest number is chosen.
// - In normal operation own transmitted frames are never stored.
// - In self-test own frames are stored and acknowledged locally.
// - Thirty-two independent mailboxes, each usable for transmission.
// - Normal transmit sets done flag on success, retries on failure.
// - Single transmit sets abort-done flag on failure, no retry.
`timescale 1ns/100ps
`default_nettype none
`include "can_cfg_regs.svh"
module can_mailbox_cfg import can_cfg_pkg::*; (
  input wire logic pclk, // Clock, 100 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire tx_event_t tx_event, // Transmit outcome from engine
  input wire rx_frame_t rx_frame, // Received frame and filter hits
  output logic [31:0] tx_pending, // Mailboxes asking to send
  output logic [31:0] tx_single, // Mailboxes with single bit set
  output logic store_valid, // Frame stored this cycle
  output logic [4:0] store_idx, // Mailbox that took the frame
  output logic ack_self, // Drive own acknowledge slot
  output logic bus_active, // Left configuration state
  output logic tq_tick, // Quantum tick
  output logic sample_pulse, // Bit sample point
  output logic bit_start // Bit start
);

  // ****************************************
  // APB slave
  // ****************************************
  logic [31:0] ctrl_r;
  logic [31:0] bitcfg_r;
  logic [7:0] mctl_r [`MBOX_N];
  logic [31:0] rdata_nxt;
  logic err_nxt;
  logic setup;
  logic done;
  logic wr;
  logic is_mb;
  logic [4:0] mb_sel;
  logic stored_r;
  logic [4:0] last_idx_r;
  logic ack_seen_r;

  assign setup = psel && !penable;
  assign done = psel && penable && pready;
  assign wr = done && pwrite && !pslverr;
  assign is_mb = (paddr[11:7] == `MCTL_PAGE);
  assign mb_sel = paddr[6:2];

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      err_nxt = 1'b1;
    end else if (paddr == `A_CTRL) begin
      rdata_nxt = ctrl_r;
    end else if (paddr == `A_BITCFG) begin
      rdata_nxt = bitcfg_r;
    end else if (paddr == `A_STATUS) begin
      rdata_nxt[`ST_CONFIG] = ctrl_r[`CTRL_CONFIG];
      rdata_nxt[`ST_SELF_TEST] = ctrl_r[`CTRL_SELF_TEST];
      rdata_nxt[`ST_QUEUE_SEL] = ctrl_r[`CTRL_QUEUE_SEL];
      rdata_nxt[`ST_STORED] = stored_r;
      rdata_nxt[`ST_ACK_SELF] = ack_seen_r;
      rdata_nxt[`ST_IDX_LSB +: 5] = last_idx_r;
    end else if (is_mb) begin
      rdata_nxt[7:0] = mctl_r[mb_sel];
    end else begin
      err_nxt = 1'b1;
    end
  end

  // One wait-free access phase; read data captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
      pslverr <= err_nxt;
    end else if (done) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // ****************************************
  // Control and bit timing
  // ****************************************
  logic cfg_mode;
  logic self_test;
  logic queue_fifo;
  bit_timing_t timing;

  assign cfg_mode = ctrl_r[`CTRL_CONFIG];
  assign self_test = ctrl_r[`CTRL_SELF_TEST];
  assign queue_fifo = ctrl_r[`CTRL_QUEUE_SEL];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CTRL_RST;
    end else if (wr && paddr == `A_CTRL) begin
      ctrl_r <= {29'h0000_0000, pwdata[2:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bitcfg_r <= `BT_RST;
    end else if (wr && paddr == `A_BITCFG && cfg_mode) begin
      bitcfg_r <= pwdata & `BT_MASK;
    end
  end

  assign timing.presc = bitcfg_r[`BT_PRESC_LSB +: `PRESC_W];
  assign timing.seg1 = bitcfg_r[`BT_SEG1_LSB +: 5];
  assign timing.seg2 = bitcfg_r[`BT_SEG2_LSB +: 4];
  assign timing.resync_jump_width = bitcfg_r[`BT_SJW_LSB +: 2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_active <= 1'b0;
    end else begin
      bus_active <= !cfg_mode;
    end
  end

  bit_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(bus_active),
    .timing(timing),
    .tq_tick(tq_tick),
    .sample_pulse(sample_pulse),
    .bit_start(bit_start)
  );

  // ****************************************
  // Receive placement
  // ****************************************
  logic [31:0] cand;
  logic found;
  logic [4:0] win_idx;
  logic frame_ok;
  logic mode_live;

  assign mode_live = !queue_fifo && !cfg_mode;
  assign frame_ok = rx_frame.valid && mode_live &&
                    (!rx_frame.own || self_test);

  // receive mode and filter both match
  genvar j;
  generate
    for (j = 0; j < `MBOX_N; j = j + 1) begin : g_cand
      assign cand[j] = frame_ok && rx_frame.match[j] &&
                       mctl_r[j][`MC_RX_REQ] && !mctl_r[j][`MC_TX_REQ];
    end
  endgenerate

  rx_mailbox_select u_sel (
    .cand(cand),
    .found(found),
    .idx(win_idx)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_valid <= 1'b0;
      store_idx <= 5'h00;
    end else begin
      store_valid <= found;
      store_idx <= win_idx;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stored_r <= 1'b0;
      last_idx_r <= 5'h00;
    end else if (found) begin
      stored_r <= 1'b1;
      last_idx_r <= win_idx;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_self <= 1'b0;
      ack_seen_r <= 1'b0;
    end else begin
      ack_self <= rx_frame.valid && rx_frame.own && self_test && !cfg_mode;
      if (rx_frame.valid && rx_frame.own && self_test && !cfg_mode) begin
        ack_seen_r <= 1'b1;
      end else if (wr && paddr == `A_CTRL) begin
        ack_seen_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Mailbox control registers
  // ****************************************
  // thirty-two mailboxes
  generate
    for (j = 0; j < `MBOX_N; j = j + 1) begin : g_mb
      logic sw_wr;
      logic tx_hit;
      logic rx_hit;
      logic [7:0] c;

      assign c = mctl_r[j];
      assign sw_wr = wr && is_mb && (mb_sel == 5'(j));
      assign tx_hit = tx_event.valid && mode_live &&
                      (tx_event.mbox == 5'(j)) &&
                      c[`MC_TX_REQ] && !c[`MC_RX_REQ];
      assign rx_hit = found && (win_idx == 5'(j));

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mctl_r[j] <= `MCTL_RST;
        end else begin
          if (sw_wr) begin
            mctl_r[j][`MC_TX_REQ] <= pwdata[`MC_TX_REQ];
            mctl_r[j][`MC_RX_REQ] <= pwdata[`MC_RX_REQ];
            mctl_r[j][`MC_SINGLE] <= pwdata[`MC_SINGLE];
          end else begin
            // single failure leaves single bit only
            // success or single attempt ends request
            if (tx_hit && (tx_event.ok || c[`MC_SINGLE])) begin
              mctl_r[j][`MC_TX_REQ] <= 1'b0;
            end
            if (rx_hit && c[`MC_SINGLE]) begin
              mctl_r[j][`MC_RX_REQ] <= 1'b0;
            end
          end
          // Flags: set wins over a clearing write
          // done flag on success, else retry
          if (tx_hit && tx_event.ok) begin
            mctl_r[j][`MC_TX_DONE] <= 1'b1;
          end else if (sw_wr && !pwdata[`MC_TX_DONE]) begin
            mctl_r[j][`MC_TX_DONE] <= 1'b0;
          end
          if (tx_hit && !tx_event.ok && c[`MC_SINGLE]) begin
            mctl_r[j][`MC_TX_ABORT_DONE] <= 1'b1;
          end else if (sw_wr && !pwdata[`MC_TX_ABORT_DONE]) begin
            mctl_r[j][`MC_TX_ABORT_DONE] <= 1'b0;
          end
          if (rx_hit) begin
            mctl_r[j][`MC_RX_DONE] <= 1'b1;
          end else if (sw_wr && !pwdata[`MC_RX_DONE]) begin
            mctl_r[j][`MC_RX_DONE] <= 1'b0;
          end
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_pending[j] <= 1'b0;
          tx_single[j] <= 1'b0;
        end else begin
          tx_pending[j] <= mode_live && c[`MC_TX_REQ] && !c[`MC_RX_REQ];
          tx_single[j] <= c[`MC_SINGLE];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ### rtl/rx_mailbox_select.sv
// Lowest-numbered qualifying mailbox for a received frame
`timescale 1ns/100ps
`default_nettype none
module rx_mailbox_select (
  input wire logic [31:0] cand, // Mailboxes that qualify
  output logic found, // Any mailbox qualifies
  output logic [4:0] idx // Winning mailbox
);
  logic [32:0] below;
  logic [31:0] first;

  assign below[0] = 1'b0;

  genvar j;
  generate
    for (j = 0; j < 32; j = j + 1) begin : g_pri
      assign below[j+1] = below[j] | cand[j];
      assign first[j] = cand[j] & ~below[j];
    end
  endgenerate

  assign found = below[32];

  always_comb begin
    idx = 5'h00;
    for (int k = 0; k < 32; k++) begin
      if (first[k]) begin
        idx = idx | k[4:0];
      end
    end
  end
endmodule
`default_nettype wire

// ### test/can_bus_node_model.sv
// Far side model: protocol engine and other bus nodes
`timescale 1ns/100ps
`default_nettype none
module can_bus_node_model import can_cfg_pkg::*; (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic tx_go, // Start one send attempt
  input wire logic lose, // Attempt fails
  input wire logic rx_go, // Deliver one frame
  input wire logic rx_own, // Frame is our own
  input wire logic [31:0] rx_match, // Filter hits
  input wire logic [31:0] tx_pending, // Mailboxes asking to send
  output tx_event_t tx_event, // Send outcome
  output rx_frame_t rx_frame // Received frame
);
  // lowest pending mailbox always wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_event <= '0;
    end else begin
      tx_event.valid <= tx_go && (|tx_pending);
      tx_event.ok <= tx_go ? !lose : ~tx_event.ok;
      for (int i = 31; i >= 0; i--) begin
        if (tx_pending[i]) tx_event.mbox <= i[4:0];
      end
    end
  end
  // Idle fields toggle so stale values are never trusted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_frame <= '0;
    end else begin
      rx_frame.valid <= rx_go;
      rx_frame.own <= rx_go ? rx_own : ~rx_frame.own;
      rx_frame.match <= rx_go ? rx_match : ~rx_frame.match;
    end
  end
endmodule
`default_nettype wire

// ### test/can_mailbox_cfg_checker.sv
// Port checker of the mailbox block
`timescale 1ns/100ps
`default_nettype none
module can_mailbox_cfg_checker import can_cfg_pkg::*; (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire tx_event_t tx_event, // Send outcome
  input wire rx_frame_t rx_frame, // Received frame
  input wire logic [31:0] tx_pending, // Sending mailboxes
  input wire logic [31:0] tx_single, // Single attempt
  input wire logic store_valid, // Stored
  input wire logic [4:0] store_idx, // Store index
  input wire logic ack_self, // Own acknowledge
  input wire logic bus_active, // Running
  input wire logic tq_tick, // Quantum
  input wire logic bit_start // Bit start
);
  logic [31:0] match_q;
  logic e1, e2, k1, k2;
  logic [4:0] m1, m2;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // Delayed copies of events
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e1 <= 1'b0;
      e2 <= 1'b0;
    end else begin
      e1 <= tx_event.valid && tx_pending[tx_event.mbox];
      e2 <= e1;
    end
  end
  always_ff @(posedge pclk) begin
    match_q <= rx_frame.match;
    m1 <= tx_event.mbox;
    k1 <= tx_event.ok || tx_single[tx_event.mbox];
    m2 <= m1;
    k2 <= k1;
  end
  a_ready_zero_wait: assert property (psel && !penable |=> pready)
    else $error("ready late");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready too long");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_read_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_store_has_cause: assert property (store_valid |-> $past(rx_frame.valid))
    else $error("store without frame");
  a_store_hit_match: assert property (store_valid |-> match_q[store_idx])
    else $error("store into unmatched mailbox");
  a_ack_own_frame: assert property (ack_self |-> $past(rx_frame.own))
    else $error("acknowledge without own frame");
  a_tx_outcome_kept: assert property (e2 |-> tx_pending[m2] == !k2)
    else $error("send outcome wrong");
  a_timer_idle_cfg: assert property (!bus_active && !$past(bus_active) &&
    !$past(bus_active, 2) |-> !tq_tick && !bit_start)
    else $error("timer runs in configuration");
endmodule
bind can_mailbox_cfg can_mailbox_cfg_checker can_mailbox_cfg_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_event(tx_event), .rx_frame(rx_frame), .tx_pending(tx_pending),
  .tx_single(tx_single), .store_valid(store_valid),
  .store_idx(store_idx), .ack_self(ack_self), .bus_active(bus_active),
  .tq_tick(tq_tick), .bit_start(bit_start));
`default_nettype wire

// ### test/can_mailbox_cfg_tb.sv
// Self-checking bench of the mailbox block
`timescale 1ns/100ps
`default_nettype none
`include "can_cfg_regs.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_mismatch++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module can_mailbox_cfg_tb import can_cfg_pkg::*; ;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, tx_pending, tx_single, rx_match = 0;
  logic pready, pslverr, store_valid, ack_self, bus_active, er;
  logic tq_tick, sample_pulse, bit_start;
  logic tx_go = 0, lose = 0, rx_go = 0, rx_own = 0;
  logic [4:0] store_idx, last_idx;
  logic [31:0] rd;
  tx_event_t tx_event;
  rx_frame_t rx_frame;
  int n_mismatch = 0, n_compared = 0, n_store = 0, n_ack = 0;
  logic [11:0] mb [5] = '{12'h000, 12'h004, 12'h00c, 12'h014, 12'h018};
  logic [31:0] md [5] = '{32'h80, 32'h90, 32'h40, 32'h40, 32'h50};
  can_mailbox_cfg can_mailbox_cfg_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_event(tx_event), .rx_frame(rx_frame), .tx_pending(tx_pending),
    .tx_single(tx_single), .store_valid(store_valid),
    .store_idx(store_idx), .ack_self(ack_self), .bus_active(bus_active),
    .tq_tick(tq_tick), .sample_pulse(sample_pulse), .bit_start(bit_start));
  can_bus_node_model can_bus_node_model_inst (.pclk(pclk),
    .presetn(presetn), .tx_go(tx_go), .lose(lose), .rx_go(rx_go),
    .rx_own(rx_own), .rx_match(rx_match), .tx_pending(tx_pending),
    .tx_event(tx_event), .rx_frame(rx_frame));
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (store_valid === 1'b1) begin
      n_store++;
      last_idx = store_idx;
    end
    if (ack_self === 1'b1) n_ack++;
  end
  task automatic complete_run();
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin n_mismatch++; complete_run(); end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
    input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK($sformatf("read %h", a), e, rd)
    `CHK($sformatf("error %h", a), ee, er)
  endtask
  function automatic logic sig(int k);
    return k == 0 ? tq_tick : (k == 1 ? sample_pulse : bit_start);
  endfunction
  task automatic gap(input int a, input int b, input int e, input string n);
    int i, j;
    i = 0;
    do begin @(posedge pclk); i++; end while (sig(a) !== 1'b1 && i < 200);
    if (sig(a) !== 1'b1) begin n_mismatch++; complete_run(); end
    j = 0;
    do begin @(posedge pclk); j++; end while (sig(b) !== 1'b1 && j < 200);
    if (sig(b) !== 1'b1) begin n_mismatch++; complete_run(); end
    `CHK(n, e, j)
  endtask
  task automatic tx(input logic l);
    lose <= l;
    tx_go <= 1'b1;
    @(posedge pclk);
    tx_go <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic frame(input logic own, input logic [31:0] m);
    rx_own <= own;
    rx_match <= m;
    rx_go <= 1'b1;
    @(posedge pclk);
    rx_go <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(`A_CTRL, `CTRL_RST, 1'b0);
    rdchk(`A_BITCFG, `BT_RST, 1'b0);
    rdchk(12'h0fc, 32'h0, 1'b1);
    rdchk(12'h002, 32'h0, 1'b1);
    apb(1'b1, `A_BITCFG, 32'h1205_03ff);
    rdchk(`A_BITCFG, 32'h1205_03ff, 1'b0);
    apb(1'b1, `A_BITCFG, 32'h1205_0002);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `A_MCTL_BASE + mb[i], 32'h0);
      apb(1'b1, `A_MCTL_BASE + mb[i], md[i]);
    end
    // speed and mailboxes set before leaving configuration
    apb(1'b1, `A_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK("bus_active", 1'b1, bus_active)
    `CHK("tx_pending", 32'h3, tx_pending)
    `CHK("tx_single", 32'h42, tx_single)
    gap(0, 0, 3, "quantum");
    gap(2, 1, 18, "sample point");
    gap(2, 2, 24, "bit length");
    apb(1'b1, `A_BITCFG, 32'h0);
    rdchk(`A_BITCFG, 32'h1205_0002, 1'b0);
    tx(1'b1);
    rdchk(`A_MCTL_BASE, 32'h80, 1'b0);
    tx(1'b0);
    rdchk(`A_MCTL_BASE, 32'h01, 1'b0);
    tx(1'b1);
    // aborted single attempt leaves the single bit and the abort-done flag
    rdchk(`A_MCTL_BASE + 12'h004, 32'h12, 1'b0);
    frame(1'b1, 32'h28);
    `CHK("own stored", 0, n_store)
    rdchk(`A_STATUS, 32'h0, 1'b0);
    frame(1'b0, 32'h28);
    `CHK("store idx", 5'd3, last_idx)
    rdchk(`A_MCTL_BASE + 12'h00c, 32'h44, 1'b0);
    frame(1'b0, 32'h44);
    `CHK("store idx", 5'd6, last_idx)
    rdchk(`A_MCTL_BASE + 12'h018, 32'h14, 1'b0);
    apb(1'b1, `A_CTRL, 32'h2);
    apb(1'b1, `A_MCTL_BASE, 32'h0);
    apb(1'b1, `A_MCTL_BASE, 32'h80);
    frame(1'b1, 32'h20);
    `CHK("store idx", 5'd5, last_idx)
    `CHK("acks", 1, n_ack)
    rdchk(`A_STATUS, 32'h0000_051a, 1'b0);
    `CHK("tx_pending", 32'h1, tx_pending)
    apb(1'b1, `A_CTRL, 32'h4);
    frame(1'b0, 32'h20);
    `CHK("stores", 3, n_store)
    `CHK("tx_pending", 32'h0, tx_pending)
    complete_run();
  end
endmodule
`default_nettype wire
